// ### src/cpm_map.svh
// register offsets, field positions, reset values and timing counts
// assumes 32-bit register data and an 8-bit register address
`ifndef CPM_MAP_SVH
`define CPM_MAP_SVH

`define CPM_PLL_CTL_OFF 8'h00
`define CPM_DIV_OFF 8'h04
`define CPM_VR_OFF 8'h08
`define CPM_MODE_OFF 8'h0C
`define CPM_STAT_OFF 8'h10

`define CPM_MULT_MSB 6
`define CPM_MULT_LSB 0
`define CPM_MULT_RST 7'h06
`define CPM_MULT_MIN 7'h05
`define CPM_MULT_MAX 7'h40

`define CPM_SSEL_MSB 3
`define CPM_SSEL_LSB 0
`define CPM_SSEL_RST 4'h4
`define CPM_CSEL_MSB 5
`define CPM_CSEL_LSB 4
`define CPM_CSEL_RST 2'h0

`define CPM_VR_HIB_N 0
`define CPM_VR_SYSTEM_CLOCK_OUT_OPTION_EN 1
`define CPM_VR_SYSTEM_CLOCK_OUT_OPTION_SEL 2
`define CPM_VR_WAKE_LVL 3

`define CPM_MODE_MSB 1
`define CPM_MODE_LSB 0
`define CPM_STAT_PG 3

`define CPM_CLK_PERIOD_NS 10
`define CPM_GPIO_WAKE_NS 10
`define CPM_GPIO_WAKE_CYC \
  ((`CPM_GPIO_WAKE_NS + `CPM_CLK_PERIOD_NS - 1) / `CPM_CLK_PERIOD_NS)

`endif

// ### src/cpm_pkg.sv
// types of the clock and power mode controller
// assumes cpm_map.svh for all numeric constants
package cpm_pkg;

  typedef enum logic [2:0] {
    M_FULL_ON = 3'b000,
    M_ACTIVE = 3'b001,
    M_SLEEP = 3'b010,
    M_DEEP = 3'b011,
    M_HIBER = 3'b100,
    M_PGWAIT = 3'b101
  } mode_e;

  typedef struct packed {
    mode_e mode;
    logic [6:0] mult;
    logic [3:0] ssel;
    logic [1:0] csel;
    logic vr_hib_n;
    logic system_clock_out_option_en;
    logic system_clock_out_option_sel;
    logic wake_lvl;
    logic [4:0] core_cnt;
    logic [3:0] core_div;
    logic [4:0] sys_cnt;
    logic [3:0] sys_div;
    logic core_clk;
    logic sys_clk;
    logic system_clock_out_option;
    logic system_clock_out_option_oe_n;
    logic reg_wake;
    logic boot;
    logic block;
    logic hiz;
    logic bypass;
    logic [31:0] rdata;
    logic rst_s1;
    logic rst_s2;
    logic gpio_s1;
    logic gpio_s2;
    logic inclk_s1;
    logic inclk_s2;
    logic pg_s1;
    logic pg_s2;
  } state_s;

endpackage

// ### src/clock_power_mode_control.sv
// clock divider and low power mode controller, one clock domain
// assumes pins arrive asynchronously and a simple strobe register port
//
// What this block does
// - deep sleep stops core and system clocks
// - deep sleep blocks async peripheral resource access
// - deep sleep wakes only on reset or gpio
// - hibernate stops clocks, tells regulator power off
// - writing zero hibernate bit lowers regulator wake
// - hibernate floats all external pins
// - regulator control register survives hibernation
// - other registers return to reset after hibernate
// - regulator wake output is active high
// - reset pin in hibernate raises wake, boots
// - start waits for low active power good
// - core and system clocks from input via pll
// - pll multiplier 5 to 64, reset 6
// - divider write changes clocks on the fly
// - clock pin selects system or inverted input
// - clock pin floats until enabled by software
// - system select divides by 1 to 15
// - system select change needs no relock
// - core select divides by 1,2,4,8
// - sleep stops only the core clock
// - active mode bypasses pll, input rate clocks
`timescale 1ns/100ps
`include "cpm_map.svh"

module clock_power_mode_control
  import cpm_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic reset_pin_n,
  input wire logic gpio_wake,
  input wire logic periph_wake,
  input wire logic input_clock_pin,
  input wire logic power_good_in_n,
  output logic core_clock,
  output logic system_clock,
  output logic [6:0] pll_mult,
  output logic pll_bypass,
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe_n,
  output logic regulator_wake_out,
  output logic async_access_block,
  output logic pins_hiz,
  output logic boot_start,
  output logic [2:0] mode_state
);

  state_s q;
  state_s d;

  // next position of a divider counter; a stopped clock freezes low
  function automatic logic [4:0] cnt_next(input logic [4:0] cnt,
                                          input logic [3:0] div,
                                          input logic run);
    logic [4:0] last;
    last = {div, 1'b0} - 5'h01;
    if (!run && cnt >= {1'b0, div}) begin
      cnt_next = cnt;
    end else if (cnt >= last) begin
      cnt_next = 5'h00;
    end else begin
      cnt_next = cnt + 5'h01;
    end
  endfunction

  logic rst_evt;
  logic gpio_evt;
  logic pg_ok;
  logic sw_ok;
  logic core_run;
  logic sys_run;
  logic bypass;
  logic [6:0] wmult;
  logic [3:0] wssel;

  always_comb begin
    d = q;
    d.boot = 1'b0;
    d.rdata = 32'h0000_0000;
    d.rst_s1 = reset_pin_n;
    d.rst_s2 = q.rst_s1;
    d.gpio_s1 = gpio_wake;
    d.gpio_s2 = q.gpio_s1;
    d.inclk_s1 = input_clock_pin;
    d.inclk_s2 = q.inclk_s1;
    d.pg_s1 = power_good_in_n;
    d.pg_s2 = q.pg_s1;
    rst_evt = !q.rst_s2;
    gpio_evt = (q.gpio_s2 == q.wake_lvl);
    pg_ok = !q.pg_s2;
    sw_ok = (q.mode == M_FULL_ON) || (q.mode == M_ACTIVE);
    wmult = wdata[`CPM_MULT_MSB:`CPM_MULT_LSB];
    wssel = wdata[`CPM_SSEL_MSB:`CPM_SSEL_LSB];

    // register writes, only while software runs
    if (wr && sw_ok) begin
      unique case (addr)
        `CPM_PLL_CTL_OFF: begin
          if (wmult >= `CPM_MULT_MIN && wmult <= `CPM_MULT_MAX) begin
            d.mult = wmult;
          end
        end
        `CPM_DIV_OFF: begin
          if (wssel != 4'h0) begin
            d.ssel = wssel;
          end
          d.csel = wdata[`CPM_CSEL_MSB:`CPM_CSEL_LSB];
        end
        `CPM_VR_OFF: begin
          d.vr_hib_n = wdata[`CPM_VR_HIB_N];
          d.system_clock_out_option_en = wdata[`CPM_VR_SYSTEM_CLOCK_OUT_OPTION_EN];
          d.system_clock_out_option_sel = wdata[`CPM_VR_SYSTEM_CLOCK_OUT_OPTION_SEL];
          d.wake_lvl = wdata[`CPM_VR_WAKE_LVL];
          if (!wdata[`CPM_VR_HIB_N]) begin
            d.mode = M_HIBER;
          end
        end
        `CPM_MODE_OFF: begin
          unique case (wdata[`CPM_MODE_MSB:`CPM_MODE_LSB])
            2'h0: d.mode = M_FULL_ON;
            2'h1: d.mode = M_ACTIVE;
            2'h2: d.mode = M_SLEEP;
            2'h3: d.mode = M_DEEP;
          endcase
        end
        default: begin
        end
      endcase
    end

    // register reads, data in the following cycle
    if (rd) begin
      unique case (addr)
        `CPM_PLL_CTL_OFF: d.rdata = {25'h0, q.mult};
        `CPM_DIV_OFF: d.rdata = {26'h0, q.csel, q.ssel};
        `CPM_VR_OFF: begin
          d.rdata = {28'h0, q.wake_lvl, q.system_clock_out_option_sel, q.system_clock_out_option_en,
                     q.vr_hib_n};
        end
        `CPM_STAT_OFF: d.rdata = {28'h0, pg_ok, q.mode};
        default: d.rdata = 32'h0000_0000;
      endcase
    end

    // mode sequencing
    unique case (q.mode)
      M_FULL_ON, M_ACTIVE: begin
      end
      M_SLEEP: begin
        if (rst_evt || gpio_evt || periph_wake) begin
          d.mode = M_FULL_ON;
        end
      end
      M_DEEP: begin
        if (rst_evt || gpio_evt) begin
          d.mode = M_FULL_ON;
        end
      end
      M_HIBER: begin
        if (rst_evt) begin
          d.mode = M_PGWAIT;
          d.mult = `CPM_MULT_RST;
          d.ssel = `CPM_SSEL_RST;
          d.csel = `CPM_CSEL_RST;
        end
      end
      M_PGWAIT: begin
        if (pg_ok) begin
          d.mode = M_FULL_ON;
          d.boot = 1'b1;
        end
      end
      default: d.mode = M_PGWAIT;
    endcase

    // clock generation from the pll output
    bypass = (d.mode == M_ACTIVE);
    core_run = (q.mode == M_FULL_ON) || (q.mode == M_ACTIVE);
    sys_run = core_run || (q.mode == M_SLEEP);
    d.core_cnt = cnt_next(q.core_cnt, q.core_div, core_run);
    d.sys_cnt = cnt_next(q.sys_cnt, q.sys_div, sys_run);
    if (d.core_cnt == 5'h00 && q.core_cnt != 5'h00) begin
      d.core_div = bypass ? 4'h1 : (4'h1 << q.csel);
    end
    if (d.sys_cnt == 5'h00 && q.sys_cnt != 5'h00) begin
      d.sys_div = bypass ? 4'h1 : q.ssel;
    end
    d.core_clk = d.core_cnt < {1'b0, d.core_div};
    d.sys_clk = d.sys_cnt < {1'b0, d.sys_div};

    // pins and regulator
    d.system_clock_out_option = q.system_clock_out_option_sel ? !q.inclk_s2 : d.sys_clk;
    d.hiz = (d.mode == M_HIBER);
    d.system_clock_out_option_oe_n = !(q.system_clock_out_option_en && !d.hiz);
    d.reg_wake = (d.mode != M_HIBER);
    d.block = (d.mode == M_DEEP);
    d.bypass = bypass;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.mode <= M_PGWAIT;
      q.mult <= `CPM_MULT_RST;
      q.ssel <= `CPM_SSEL_RST;
      q.csel <= `CPM_CSEL_RST;
      q.vr_hib_n <= 1'b1;
      q.core_div <= 4'h1;
      q.sys_div <= 4'h1;
      q.system_clock_out_option_oe_n <= 1'b1;
      q.reg_wake <= 1'b1;
      q.rst_s1 <= 1'b1;
      q.rst_s2 <= 1'b1;
      q.pg_s1 <= 1'b1;
      q.pg_s2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign core_clock = q.core_clk;
  assign system_clock = q.sys_clk;
  assign pll_mult = q.mult;
  assign pll_bypass = q.bypass;
  assign clock_output_pin_o = q.system_clock_out_option;
  assign clock_output_pin_oe_n = q.system_clock_out_option_oe_n;
  assign regulator_wake_out = q.reg_wake;
  assign async_access_block = q.block;
  assign pins_hiz = q.hiz;
  assign boot_start = q.boot;
  assign mode_state = q.mode;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  deep_core_stop_a: assert property (
    q.mode == M_DEEP && !q.core_clk && $past(q.mode) == M_DEEP
      |=> !q.core_clk || q.mode != M_DEEP)
    else $error("core clock toggled in deep sleep");
  deep_sys_stop_a: assert property (
    q.mode == M_DEEP && $past(q.mode) == M_DEEP && !q.sys_clk
      |=> !q.sys_clk || q.mode != M_DEEP)
    else $error("system clock toggled in deep sleep");
  deep_block_a: assert property (
    q.mode == M_DEEP |-> q.block)
    else $error("async access not blocked in deep sleep");
  deep_ignore_a: assert property (
    q.mode == M_DEEP && q.rst_s2 && q.gpio_s2 != q.wake_lvl
      |=> q.mode == M_DEEP)
    else $error("deep sleep left on a foreign wake");
  hib_wake_low_a: assert property (
    wr && addr == `CPM_VR_OFF && !wdata[`CPM_VR_HIB_N] &&
      (q.mode == M_FULL_ON || q.mode == M_ACTIVE)
      |=> !regulator_wake_out && pins_hiz && clock_output_pin_oe_n)
    else $error("hibernate write did not drop regulator wake");
  vr_keep_a: assert property (
    $past(q.mode) == M_HIBER && q.mode == M_PGWAIT
      |-> $stable(q.system_clock_out_option_en) && $stable(q.wake_lvl))
    else $error("regulator control lost in hibernate");
  pg_hold_a: assert property (
    q.mode == M_PGWAIT && q.pg_s2 |=> q.mode == M_PGWAIT && !boot_start)
    else $error("started without power good");
  boot_src_a: assert property (
    boot_start |-> $past(q.mode) == M_PGWAIT && regulator_wake_out)
    else $error("boot pulse without wake sequence");
  mult_range_a: assert property (
    q.mult >= `CPM_MULT_MIN && q.mult <= `CPM_MULT_MAX)
    else $error("pll multiplier out of range");
  ssel_zero_a: assert property (
    wr && addr == `CPM_DIV_OFF && wdata[3:0] == 4'h0 &&
      (q.mode == M_FULL_ON || q.mode == M_ACTIVE) |=> $stable(q.ssel))
    else $error("zero system select was taken");

  // mode, pin and divider guards
  sleep_core_stop_a: assert property (
    q.mode == M_SLEEP && !q.core_clk |=>
      !q.core_clk || q.mode != M_SLEEP)
    else $error("core clock toggled in sleep");
  hib_clk_stop_a: assert property (
    q.mode == M_HIBER && !q.core_clk && !q.sys_clk |=>
      (!q.core_clk && !q.sys_clk) || q.mode != M_HIBER)
    else $error("clock toggled in hibernate");
  hib_pins_a: assert property (
    q.mode == M_HIBER |-> pins_hiz && clock_output_pin_oe_n)
    else $error("pin driven in hibernate");
  wake_level_a: assert property (
    regulator_wake_out == (q.mode != M_HIBER))
    else $error("regulator wake level wrong for mode");
  hib_exit_a: assert property (
    q.mode == M_HIBER && !q.rst_s2 |=>
      q.mode == M_PGWAIT && regulator_wake_out)
    else $error("reset pin did not wake the regulator");
  pin_idle_a: assert property (
    !$past(q.system_clock_out_option_en) |-> clock_output_pin_oe_n)
    else $error("clock pin driven while disabled");
  clk_pin_sel_a: assert property (
    !$past(q.system_clock_out_option_sel) |-> clock_output_pin_o == system_clock)
    else $error("clock pin not showing system clock");
  active_div_a: assert property (
    q.mode == M_ACTIVE |-> (q.core_cnt != 5'h00 || q.core_div == 4'h1) &&
      (q.sys_cnt != 5'h00 || q.sys_div == 4'h1))
    else $error("active mode divider not bypassed");
  core_div_edge_a: assert property (
    $changed(q.core_div) |-> q.core_cnt == 5'h00)
    else $error("core divider changed mid period");
  sys_div_edge_a: assert property (
    $changed(q.sys_div) |-> q.sys_cnt == 5'h00)
    else $error("system divider changed mid period");
  ssel_nonzero_a: assert property (
    q.ssel != 4'h0 && q.sys_div != 4'h0)
    else $error("system divider reached zero");
  sys_div_load_a: assert property (
    $changed(q.ssel) |->
      ##[1:30] (q.sys_div == q.ssel || q.mode != M_FULL_ON))
    else $error("system divider not applied");
  core_div_load_a: assert property (
    $changed(q.csel) |->
      ##[1:16] (q.core_div == (4'h1 << q.csel) || q.mode != M_FULL_ON))
    else $error("core divider not applied");
  hib_reset_a: assert property (
    $past(q.mode) == M_HIBER && q.mode == M_PGWAIT |->
      q.mult == `CPM_MULT_RST && q.ssel == `CPM_SSEL_RST &&
      q.csel == `CPM_CSEL_RST)
    else $error("register kept across hibernate");
  deep_exit_a: assert property (
    q.mode == M_DEEP && !q.rst_s2 |=> q.mode == M_FULL_ON)
    else $error("deep sleep missed a reset pin wake");
  power_boot_a: assert property (
    q.mode == M_PGWAIT && !q.pg_s2 |=> q.mode == M_FULL_ON && boot_start)
    else $error("power good did not start boot");

  deep_wake_c: cover property (q.mode == M_DEEP ##1 q.mode == M_FULL_ON);
  hib_trip_c: cover property (q.mode == M_HIBER ##[1:20] boot_start);
  sleep_wake_c: cover property (q.mode == M_SLEEP ##1 q.mode == M_FULL_ON);
  active_trip_c: cover property (q.mode == M_ACTIVE ##1 q.mode == M_FULL_ON);
  inv_pin_c: cover property (!clock_output_pin_oe_n && q.system_clock_out_option_sel);

endmodule // clock_power_mode_control

// ### test/cpm_partner.sv
// regulator and clock source beside the power mode controller
// assumes regulator_wake_out high asks for core power
`timescale 1ns/100ps
module cpm_partner (
  input wire logic clk,
  input wire logic regulator_wake_out,
  output logic input_clock_pin,
  output logic power_good_in_n
);
  int ramp = 0;
  initial input_clock_pin = 1'b0;
  // free running source, never halted
  always #37 input_clock_pin = ~input_clock_pin;
  // supply ramps while wake is high, drops at once when low
  always @(posedge clk) begin
    if (!regulator_wake_out) ramp <= 0;
    else if (ramp < 6) ramp <= ramp + 1;
  end
  assign power_good_in_n = (ramp < 6);
endmodule // cpm_partner

// ### test/tb_clock_power_mode_control.sv
// self-checking bench of the clock and power mode controller
// assumes cpm_map.svh offsets and the partner model
`timescale 1ns/100ps
`include "cpm_map.svh"
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin \
  fail_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb_clock_power_mode_control;
  logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, rd_seen = 1'b0;
  logic reset_pin_n = 1'b1, gpio_wake = 1'b1, periph_wake = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, e, m;
  logic core_clock, system_clock, pll_bypass, ck_o, oe_n, reg_wake;
  logic blk, hiz, boot_start, inclk, pg_n;
  logic [6:0] pll_mult;
  logic [2:0] mode_state;
  logic [31:0] exp_q[$], msk_q[$];
  int fail_count = 0, samples_checked = 0, seed = 32'h549a, n, c, s, k;
  always #5 clk = ~clk;
  clock_power_mode_control clock_power_mode_control_i (.clk(clk),
    .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .reset_pin_n(reset_pin_n), .gpio_wake(gpio_wake),
    .periph_wake(periph_wake), .input_clock_pin(inclk),
    .power_good_in_n(pg_n), .core_clock(core_clock),
    .system_clock(system_clock), .pll_mult(pll_mult),
    .pll_bypass(pll_bypass), .clock_output_pin_o(ck_o),
    .clock_output_pin_oe_n(oe_n), .regulator_wake_out(reg_wake),
    .async_access_block(blk), .pins_hiz(hiz), .boot_start(boot_start),
    .mode_state(mode_state));
  cpm_partner cpm_partner_i (.clk(clk), .regulator_wake_out(reg_wake),
    .input_clock_pin(inclk), .power_good_in_n(pg_n));
  // read data stands in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      `CHK("rdata", e, rdata & m)
    end
    rd_seen <= rd;
  end
  task cyc(input int t);
    repeat (t) @(posedge clk);
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a; wdata <= d; wr <= 1'b1; @(posedge clk);
    wr <= 1'b0; @(posedge clk);
  endtask
  task rreg(input logic [7:0] a, input logic [31:0] x,
            input logic [31:0] mk = 32'hFFFF_FFFF);
    exp_q.push_back(x); msk_q.push_back(mk);
    addr <= a; rd <= 1'b1; @(posedge clk);
    rd <= 1'b0; @(posedge clk);
  endtask
  // length of one high phase of the core (0) or system (1) clock
  task hi_len(input bit sy, output int len);
    len = 0;
    repeat (40) begin @(posedge clk);
      if ((sy ? system_clock : core_clock) === 1'b0) break; end
    repeat (40) begin @(posedge clk);
      if ((sy ? system_clock : core_clock) === 1'b1) break; end
    repeat (40) begin @(posedge clk); len++;
      if ((sy ? system_clock : core_clock) !== 1'b1) break; end
  endtask
  task togs(output int tc, output int ts);
    logic pc, ps;
    tc = 0; ts = 0; pc = core_clock; ps = system_clock;
    repeat (40) begin @(posedge clk);
      if (core_clock !== pc) tc++;
      if (system_clock !== ps) ts++;
      pc = core_clock; ps = system_clock; end
  endtask
  task ck_togs(output int t);
    logic p;
    t = 0; p = ck_o;
    repeat (40) begin @(posedge clk);
      if (ck_o !== p) t++;
      p = ck_o; end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    conclude();
  end
  initial begin
    cyc(4); srst <= 1'b0;
    for (k = 0; k < 50 && mode_state !== 3'h0; k++) cyc(1);
    `CHK("mode", 3'h0, mode_state)
    rreg(`CPM_PLL_CTL_OFF, 32'h6);
    rreg(`CPM_DIV_OFF, 32'h4);
    rreg(`CPM_VR_OFF, 32'h1);
    rreg(8'h14, 32'h0);
    `CHK("oe_n", 1'b1, oe_n)
    wreg(`CPM_PLL_CTL_OFF, 32'h4); wreg(`CPM_PLL_CTL_OFF, 32'h41);
    rreg(`CPM_PLL_CTL_OFF, 32'h6);
    n = 5 + ({$random(seed)} % 60);
    wreg(`CPM_PLL_CTL_OFF, n);
    rreg(`CPM_PLL_CTL_OFF, n);
    `CHK("mult", n[6:0], pll_mult)
    for (k = 0; k < 4; k++) begin
      wreg(`CPM_DIV_OFF, (k << 4) | (k * 4 + 2));
      cyc(40); hi_len(0, c); hi_len(1, s);
      `CHK("core_div", 1 << k, c)
      `CHK("sys_div", k * 4 + 2, s)
    end
    wreg(`CPM_DIV_OFF, 32'h0);
    rreg(`CPM_DIV_OFF, 32'hE, 32'hF);
    wreg(`CPM_MODE_OFF, 32'h1); cyc(40);
    `CHK("bypass", 1'b1, pll_bypass)
    hi_len(0, c); hi_len(1, s);
    `CHK("act_rate", 2, c + s)
    wreg(`CPM_MODE_OFF, 32'h0);
    wreg(`CPM_VR_OFF, 32'h7); cyc(3);
    `CHK("oe_n", 1'b0, oe_n)
    ck_togs(c);
    `CHK("ck_inv", 1'b1, c >= 9 && c <= 12)
    wreg(`CPM_MODE_OFF, 32'h2); cyc(20); togs(c, s);
    `CHK("sleep", 1'b1, c == 0 && s > 0)
    periph_wake <= 1'b1; cyc(5); periph_wake <= 1'b0;
    `CHK("sleep_exit", 1'b1, mode_state !== 3'h2)
    wreg(`CPM_MODE_OFF, 32'h3); cyc(20); togs(c, s);
    `CHK("deep_clk", 0, c + s)
    `CHK("block", 1'b1, blk)
    periph_wake <= 1'b1; cyc(5); periph_wake <= 1'b0;
    `CHK("deep_hold", 3'h3, mode_state)
    gpio_wake <= 1'b0; cyc(2); gpio_wake <= 1'b1; cyc(6);
    `CHK("deep_exit", 2'b00, {mode_state === 3'h3, blk})
    wreg(`CPM_VR_OFF, 32'h2); cyc(20); togs(c, s);
    `CHK("hib", 4'h7, {reg_wake, hiz, oe_n, c + s == 0})
    `CHK("hib_pins", 1'b1, hiz)
    reset_pin_n <= 1'b0; cyc(5);
    `CHK("wake", 1'b1, reg_wake)
    reset_pin_n <= 1'b1;
    for (k = 0; k < 40 && boot_start !== 1'b1; k++) cyc(1);
    `CHK("boot", 2'b10, {boot_start, pg_n})
    cyc(3);
    rreg(`CPM_PLL_CTL_OFF, 32'h6);
    rreg(`CPM_VR_OFF, 32'h2);
    cyc(30); ck_togs(c);
    `CHK("ck_sys", 10, c)
    cyc(3);
    conclude();
  end
endmodule // tb_clock_power_mode_control
